// >>> bench/paxio_drive_model.sv
// Purpose: motor driver and sensor model for one axis
// Assumes: sensors other than settled and fault are levels derived from the pulses the driver has counted
// Notes:   settled input lags the last pulse by SETTLE_DLY cycles, so slow servos show
module paxio_drive_model
  import paxio_pkg::*;
#(
  parameter int SETTLE_DLY = 6
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire paxio_pins_t             pins,
  input  wire paxio_mode_t             mode,
  input  wire logic signed [POS_W-1:0] lim_fwd,
  input  wire logic signed [POS_W-1:0] lim_rev,
  input  wire logic signed [POS_W-1:0] home_at,
  input  wire logic                    fault_req,
  output paxio_sense_t                 sense,
  output logic signed [POS_W-1:0]      mpos,
  output int                           bad
);
  timeunit 1ns;
  timeprecision 1ps;
  paxio_pins_t prev;
  int          quiet;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev  <= '0;
      mpos  <= '0;
      quiet <= 0;
      bad   <= 0;
    end else begin
      prev  <= pins;
      quiet <= (pins.fwd_pulse_true | pins.rev_pulse_true) ? 0 : quiet + 1;
      if (pins.fwd_pulse_true && !prev.fwd_pulse_true) mpos <= mpos + 1;
      else if (pins.rev_pulse_true && !prev.rev_pulse_true) mpos <= mpos - 1;
      if (pins.fwd_pulse_inv !== ~pins.fwd_pulse_true) bad <= bad + 1;
      else if (pins.rev_pulse_inv !== ~pins.rev_pulse_true) bad <= bad + 1;
      else if (pins.fwd_pulse_true & pins.rev_pulse_true) bad <= bad + 1;
    end
  end

  // the limit, settled and fault sensors read their level through the configured active sense; home sensors are active high
  always_comb begin
    sense                   = '0;
    sense.fwd_overtravel_in = (mpos >= lim_fwd) ~^ mode.lmt_lvl;
    sense.rev_overtravel_in = (mpos <= lim_rev) ~^ mode.lmt_lvl;
    sense.near_home_in      = mpos >= home_at - 2;
    sense.home_sensor_in    = mpos >= home_at;
    sense.encoder_index_in  = mpos >= home_at + 1;
    sense.servo_settled_in  = (quiet >= SETTLE_DLY) ~^ mode.inpos_lvl;
    sense.servo_fault_in    = fault_req ~^ mode.alarm_lvl;
  end
endmodule : paxio_drive_model

// >>> bench/tb_pulse_axis_io_control.sv
// Purpose: self-checking bench for the pulse axis io block
// Assumes: short lamp and blink counts; both axes face a driver model
// Notes:   moves are kept to a few pulses so the run stays short
module tb_pulse_axis_io_control
  import paxio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic ab;
    logic signed [POS_W-1:0] tgt;
    logic [PER_W-1:0] per;
    logic signed [POS_W-1:0] exp;
  } paxio_row_t;
  logic clk = 1'b0;
  logic rst_b, emg_b, rx_on, tx_on, rx_led, tx_led;
  paxio_cmd_t [1:0] drive_cmd;
  paxio_home_t [1:0] home_cfg;
  paxio_mode_t [1:0] mode_cfg;
  paxio_out_t [1:0] out_cmd;
  paxio_sense_t [1:0] sense;
  paxio_pins_t [1:0] axis_pins;
  logic [1:0] err_clr, axis_led, axis_busy, axis_err, fault_req;
  logic signed [1:0][POS_W-1:0] axis_pos;
  logic signed [POS_W-1:0] lim_fwd [2], lim_rev [2], home_at [2], mpos [2];
  int bad [2];
  int fails = 0;
  int cmp_count = 0;
  int n, g;
  int r [3];
  paxio_row_t rows [5] = '{
    '{1'b0, 24'h000002, 16'h0004, 24'h000002}, '{1'b0, 24'hfffffd, 16'h0002, 24'hffffff},
    '{1'b1, 24'h000005, 16'h0003, 24'h000005}, '{1'b0, 24'h000000, 16'h0002, 24'h000005},
    '{1'b1, 24'hfffff8, 16'h0002, 24'hfffff8}};

  always #2 clk = ~clk;

  paxio_ctrl #(.NUM_AXES(2), .LAMP_CYC(16), .BLINK_CYC(4)) paxio_ctrl_i (
    .clk(clk), .rst_b(rst_b), .drive_cmd(drive_cmd), .home_cfg(home_cfg),
    .mode_cfg(mode_cfg), .out_cmd(out_cmd), .sense(sense), .err_clr(err_clr),
    .emergency_halt_in_b(emg_b), .rx_active(rx_on), .tx_active(tx_on),
    .axis_pins(axis_pins), .axis_led(axis_led), .axis_busy(axis_busy),
    .axis_err(axis_err), .axis_pos(axis_pos), .rx_led(rx_led), .tx_led(tx_led));

  for (genvar a = 0; a < 2; a++) begin : g_ax
    paxio_drive_model paxio_drive_model_i (
      .clk(clk), .rst_b(rst_b), .pins(axis_pins[a]), .mode(mode_cfg[a]),
      .lim_fwd(lim_fwd[a]), .lim_rev(lim_rev[a]), .home_at(home_at[a]),
      .fault_req(fault_req[a]), .sense(sense[a]), .mpos(mpos[a]), .bad(bad[a]));
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic go(input int a, input logic h, input logic ab,
                    input logic signed [POS_W-1:0] t, input logic [PER_W-1:0] p);
    @(posedge clk);
    drive_cmd[a] <= '{1'b1, h, ab, t, p};
    @(posedge clk);
    drive_cmd[a].start <= 1'b0;
  endtask : go

  // counts cycles until idle and the cycles the general output stood high
  task automatic idle(input int a, input int mn, output int nc, output int gc);
    nc = 0;
    gc = 0;
    #1;
    do begin
      if (axis_pins[a].general_output_dev_clear === 1'b1) gc++;
      @(posedge clk);
      #1;
      nc++;
    end while ((axis_busy[a] === 1'b1 || nc < mn) && nc < 3000);
    if (nc >= 3000) chk("idle_wait", 32'h0, 32'h1);
  endtask : idle

  task automatic clr;
    @(posedge clk);
    err_clr <= 2'h3;
    @(posedge clk);
    err_clr <= 2'h0;
  endtask : clr

  task automatic rises(output int rc [3]);
    logic [2:0] v, p;
    rc = '{0, 0, 0};
    p = {tx_led, rx_led, axis_led[0]};
    repeat (16) begin
      @(posedge clk);
      #1;
      v = {tx_led, rx_led, axis_led[0]};
      for (int k = 0; k < 3; k++) if (v[k] && !p[k]) rc[k]++;
      p = v;
    end
  endtask : rises

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    emg_b = 1'b1;
    rx_on = 1'b1;
    tx_on = 1'b0;
    drive_cmd = '0;
    home_cfg = '0;
    mode_cfg = '0;
    out_cmd = '0;
    err_clr = '0;
    fault_req = '0;
    lim_fwd = '{24'h7fffff, 24'h7fffff};
    lim_rev = '{24'h800000, 24'h800000};
    home_at = '{24'h100000, 24'h100000};
    repeat (12) @(posedge clk);
    chk("reset_pins", axis_pins, 10'h14a);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    foreach (rows[i]) begin
      go(0, 1'b0, rows[i].ab, rows[i].tgt, rows[i].per);
      idle(0, 1, n, g);
      chk("pos", $signed(axis_pos[0]), rows[i].exp);
      chk("model_pos", mpos[0], rows[i].exp);
    end
    go(0, 1'b0, 1'b0, 24'h000010, 16'h0004);
    repeat (6) @(posedge clk);
    rst_b <= 1'b0;
    #1 chk("midmove_reset_pins", axis_pins, 10'h14a);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (14) @(posedge clk);
    #1 chk("lamp_on", axis_led, 2'h3);
    repeat (3) @(posedge clk);
    #1 chk("lamp_off", axis_led, 2'h0);
    @(posedge clk);
    out_cmd[0] <= '{1'b1, 1'b1, 1'b0, 16'h0000};
    @(posedge clk);
    out_cmd[0].set <= 1'b0;
    #1 chk("gout_level", axis_pins[0].general_output_dev_clear, 1'b1);
    @(posedge clk);
    out_cmd[0] <= '{1'b1, 1'b0, 1'b0, 16'h0000};
    @(posedge clk);
    out_cmd[0] <= '{1'b0, 1'b0, 1'b1, 16'h0003};
    #1 chk("gout_off", axis_pins[0].general_output_dev_clear, 1'b0);
    @(posedge clk);
    out_cmd[0].pulse <= 1'b0;
    idle(0, 8, n, g);
    chk("gout_pulse", g, 3);
    go(0, 1'b0, 1'b0, 24'h000001, 16'h0004);
    @(posedge clk);
    #1 chk("led_busy", axis_led[0], 1'b1);
    idle(0, 1, n, g);
    // one of the four busy cycles went by during the indicator check
    chk("busy_plain", n, 3);
    @(posedge clk);
    mode_cfg[0].inpos_en <= 1'b1;
    mode_cfg[0].inpos_lvl <= 1'b1;
    go(0, 1'b0, 1'b0, 24'h000001, 16'h0004);
    idle(0, 1, n, g);
    // settled shows after six quiet model samples, two of them in the last period
    chk("busy_settle", n, 9);
    @(posedge clk);
    mode_cfg[0] <= '0;
    lim_fwd[0] <= mpos[0] + 3;
    go(0, 1'b0, 1'b0, 24'h00000a, 16'h0004);
    idle(0, 1, n, g);
    chk("lmt_instant", mpos[0], lim_fwd[0]);
    chk("lmt_err", axis_err[0], 1'b1);
    clr();
    go(0, 1'b0, 1'b0, 24'hfffffe, 16'h0004);
    idle(0, 1, n, g);
    chk("lmt_opposite", mpos[0], lim_fwd[0] - 2);
    @(posedge clk);
    mode_cfg[0].lmt_decel <= 1'b1;
    mode_cfg[0].lmt_lvl <= 1'b1;
    lim_fwd[0] <= mpos[0] + 3;
    go(0, 1'b0, 1'b0, 24'h000014, 16'h0004);
    idle(0, 1, n, g);
    // the period cut by the limit counts as the first decel period
    chk("lmt_decel", mpos[0], lim_fwd[0] + DECEL_PULSES - 1);
    clr();
    @(posedge clk);
    mode_cfg[0].lmt_decel <= 1'b0;
    lim_rev[0] <= mpos[0] - 2;
    go(0, 1'b0, 1'b0, 24'hffffec, 16'h0004);
    idle(0, 1, n, g);
    chk("lmt_rev", mpos[0], lim_rev[0]);
    clr();
    @(posedge clk);
    lim_fwd[0] <= 24'h7fffff;
    lim_rev[0] <= 24'h800000;
    home_at[0] <= mpos[0] + 6;
    home_cfg[0] <= '{4'hf, 4'h0, 24'h000002, 1'b1, 1'b1, 16'h0005};
    go(0, 1'b1, 1'b0, 24'h000000, 16'h0004);
    idle(0, 1, n, g);
    chk("dev_clr_width", g, 5);
    chk("home_order", mpos[0] >= home_at[0] + 3, 1'b1);
    go(0, 1'b0, 1'b0, 24'h000032, 16'h0004);
    go(1, 1'b0, 1'b0, 24'h000032, 16'h0004);
    repeat (5) @(posedge clk);
    emg_b <= 1'b0;
    go(0, 1'b0, 1'b0, 24'h000005, 16'h0004);
    repeat (2) @(posedge clk);
    #1 chk("halt_busy", axis_busy, 2'h0);
    chk("halt_pins", {axis_pins[1].fwd_pulse_true, axis_pins[0].fwd_pulse_true}, 2'h0);
    chk("halt_err", axis_err, 2'h3);
    @(posedge clk);
    emg_b <= 1'b1;
    clr();
    @(posedge clk);
    fault_req[0] <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("fault_ignored", axis_err[0], 1'b0);
    @(posedge clk);
    mode_cfg[0].alarm_en <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("fault_seen", axis_err[0], 1'b1);
    rises(r);
    chk("err_blink", r[0], 2);
    chk("rx_blink", r[1], 2);
    chk("tx_quiet", r[2], 0);
    @(posedge clk);
    tx_on <= 1'b1;
    repeat (2) @(posedge clk);
    #1 rises(r);
    chk("tx_blink", r[2], 2);
    chk("pair_faults", bad[0] + bad[1], 0);
    tally_and_finish();
  end
endmodule : tb_pulse_axis_io_control

// >>> hdl/paxio_ctrl.sv
// Purpose: per-axis pulse train, general output, sensor handling and indicators
// Assumes: speed profile reduces to a pulse period per move; inputs synchronous
// Notes:   direction 0 is the forward pair; position wraps silently at its range
module paxio_ctrl
  import paxio_pkg::*;
#(
  parameter int NUM_AXES     = 2,
  parameter int LAMP_CYC     = LAMP_CYCLES,
  parameter int BLINK_CYC    = BLINK_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire paxio_cmd_t   [NUM_AXES-1:0]       drive_cmd,
  input  wire paxio_home_t  [NUM_AXES-1:0]       home_cfg,
  input  wire paxio_mode_t  [NUM_AXES-1:0]       mode_cfg,
  input  wire paxio_out_t   [NUM_AXES-1:0]       out_cmd,
  input  wire paxio_sense_t [NUM_AXES-1:0]       sense,
  input  wire logic         [NUM_AXES-1:0]       err_clr,
  input  wire logic                              emergency_halt_in_b,
  input  wire logic                              rx_active,
  input  wire logic                              tx_active,
  output paxio_pins_t       [NUM_AXES-1:0]       axis_pins,
  output logic              [NUM_AXES-1:0]       axis_led,
  output logic              [NUM_AXES-1:0]       axis_busy,
  output logic              [NUM_AXES-1:0]       axis_err,
  output logic signed       [NUM_AXES-1:0][POS_W-1:0] axis_pos,
  output logic                                   rx_led,
  output logic                                   tx_led
);

  typedef struct packed {
    paxio_axis_t [NUM_AXES-1:0] ax;
    logic [31:0]                lamp_cnt;
    logic [31:0]                blink_cnt;
    logic                       blink;
    logic                       rx_led;
    logic                       tx_led;
  } paxio_state_t;

  paxio_state_t            s;
  paxio_state_t            next_s;
  logic [NUM_AXES-1:0]     devclr_fire;

  if (NUM_AXES < 1 || LAMP_CYC < 8 || BLINK_CYC < 1) begin : g_param_check
    $error("paxio_ctrl: unsupported parameter values");
  end

  // first enabled home step at or after 'from'; 4 means none left
  function automatic logic [2:0] paxio_next_step(input logic [3:0] en, input logic [2:0] from);
    paxio_next_step = 3'h4;
    for (int k = 3; k >= 0; k--) begin
      if (en[k] && 3'(k) >= from) begin
        paxio_next_step = 3'(k);
      end
    end
  endfunction : paxio_next_step

  function automatic paxio_axis_t paxio_load_step(input paxio_axis_t a, input logic [1:0] step,
                                                   input paxio_home_t h);
    paxio_load_step         = a;
    paxio_load_step.hstep   = step;
    paxio_load_step.dir     = h.step_rev[step];
    paxio_load_step.remain  = h.offset;
    paxio_load_step.per_cnt = '0;
  endfunction : paxio_load_step

  always_comb begin
    paxio_axis_t             a;
    logic                    emergency_halt_in;
    logic                    alarm;
    logic                    lmt_hit;
    logic                    moving;
    logic                    wrap;
    logic                    step_done;
    logic                    finish;
    logic                    lamp_on;
    logic [2:0]              nstep;
    logic signed [POS_W:0]   diff;
    logic [POS_W-1:0]        mag;
    a         = '0;
    emergency_halt_in       = !emergency_halt_in_b;
    alarm     = 1'b0;
    lmt_hit   = 1'b0;
    moving    = 1'b0;
    wrap      = 1'b0;
    step_done = 1'b0;
    finish    = 1'b0;
    lamp_on   = 1'b0;
    nstep     = 3'h4;
    diff      = '0;
    mag       = '0;
    next_s    = s;
    devclr_fire = '0;
    // blink divider: one enable per half blink period
    if (s.blink_cnt >= 32'(BLINK_CYC - 1)) begin
      next_s.blink_cnt = '0;
      next_s.blink     = !s.blink;
    end else begin
      next_s.blink_cnt = s.blink_cnt + 32'h1;
    end
    if (s.lamp_cnt != 32'h0) begin
      next_s.lamp_cnt = s.lamp_cnt - 32'h1;
    end
    lamp_on       = s.lamp_cnt > 32'h1;
    next_s.rx_led = rx_active && next_s.blink;
    next_s.tx_led = tx_active && next_s.blink;
    for (int i = 0; i < NUM_AXES; i++) begin
      a      = s.ax[i];
      alarm  = mode_cfg[i].alarm_en && (sense[i].servo_fault_in == mode_cfg[i].alarm_lvl);
      moving = (a.st == ST_RUN) || (a.st == ST_DECEL);
      wrap   = moving && (a.per_cnt >= a.period - 1'b1);
      finish = 1'b0;
      if (err_clr[i]) begin
        a.err = 1'b0;
      end
      if (moving) begin
        a.per_cnt = wrap ? '0 : a.per_cnt + 1'b1;
        if (wrap) begin
          a.pos = a.dir ? a.pos - 1'b1 : a.pos + 1'b1;
          if (!a.homing || a.hstep == HS_OFFSET) begin
            a.remain = a.remain - 1'b1;
          end
          if (a.st == ST_DECEL) begin
            a.decel_left = a.decel_left - 8'h1;
          end
        end
      end
      if (a.st == ST_RUN) begin
        if (a.homing) begin
          // sensor steps end on a period boundary, so no pulse is cut short or merged
          unique case (a.hstep)
            HS_NEAR:   step_done = wrap && sense[i].near_home_in;
            HS_HOME:   step_done = wrap && sense[i].home_sensor_in;
            HS_INDEX:  step_done = wrap && sense[i].encoder_index_in;
            HS_OFFSET: step_done = (s.ax[i].remain == '0) || (wrap && s.ax[i].remain == 24'h1);
          endcase
          if (step_done) begin
            if (a.hstep == HS_INDEX && home_cfg[i].dev_clr_en) begin
              devclr_fire[i] = 1'b1;
            end
            nstep = paxio_next_step(home_cfg[i].step_en, {1'b0, a.hstep} + 3'h1);
            if (nstep[2]) begin
              finish = 1'b1;
            end else begin
              a = paxio_load_step(a, nstep[1:0], home_cfg[i]);
            end
          end
        end else if (wrap && s.ax[i].remain == 24'h1) begin
          finish = 1'b1;
        end
      end
      if (finish) begin
        a.st     = mode_cfg[i].inpos_en ? ST_SETTLE : ST_IDLE;
        a.homing = 1'b0;
      end
      if (a.st == ST_DECEL && wrap && s.ax[i].decel_left == 8'h1) begin
        a.st = ST_IDLE;
      end
      // only the direction being pulsed is checked, so the way back stays open
      lmt_hit = a.dir ? (sense[i].rev_overtravel_in == mode_cfg[i].lmt_lvl)
                      : (sense[i].fwd_overtravel_in == mode_cfg[i].lmt_lvl);
      if (moving && lmt_hit) begin
        a.err    = 1'b1;
        a.homing = 1'b0;
        if (!mode_cfg[i].lmt_decel) begin
          a.st = ST_IDLE;
        end else if (a.st == ST_RUN) begin
          a.st         = ST_DECEL;
          a.decel_left = DECEL_PULSES;
        end
      end
      if (a.st == ST_SETTLE &&
          (!mode_cfg[i].inpos_en || sense[i].servo_settled_in == mode_cfg[i].inpos_lvl)) begin
        a.st = ST_IDLE;
      end
      if (s.ax[i].st == ST_IDLE && drive_cmd[i].start && !emergency_halt_in && !alarm) begin
        a.period  = (drive_cmd[i].period < MIN_PERIOD) ? MIN_PERIOD : drive_cmd[i].period;
        a.per_cnt = '0;
        if (drive_cmd[i].home) begin
          nstep = paxio_next_step(home_cfg[i].step_en, 3'h0);
          if (!nstep[2]) begin
            a        = paxio_load_step(a, nstep[1:0], home_cfg[i]);
            a.homing = 1'b1;
            a.st     = ST_RUN;
          end
        end else begin
          diff = drive_cmd[i].abs_tgt
               ? {drive_cmd[i].target[POS_W-1], drive_cmd[i].target} - {a.pos[POS_W-1], a.pos}
               : {drive_cmd[i].target[POS_W-1], drive_cmd[i].target};
          mag  = diff[POS_W] ? POS_W'(-diff) : diff[POS_W-1:0];
          if (mag != '0) begin
            a.dir    = diff[POS_W];
            a.remain = mag;
            a.st     = ST_RUN;
          end
        end
      end
      // fault and emergency halt cut the pulse train mid-period, no deceleration
      if (alarm || (emergency_halt_in && a.st != ST_IDLE)) begin
        a.st     = ST_IDLE;
        a.homing = 1'b0;
        a.err    = 1'b1;
      end
      if (a.gp_cnt != '0) begin
        a.gp_cnt = a.gp_cnt - 1'b1;
      end
      if (out_cmd[i].set) begin
        a.gout_lvl = out_cmd[i].val;
      end
      if (out_cmd[i].pulse) begin
        a.gp_cnt = (out_cmd[i].width == '0) ? PER_W'(1) : out_cmd[i].width;
        a.gp_lvl = 1'b1;
      end
      if (devclr_fire[i]) begin
        a.gp_cnt = (home_cfg[i].dev_clr_width == '0) ? PER_W'(1) : home_cfg[i].dev_clr_width;
        a.gp_lvl = home_cfg[i].dev_clr_lvl;
      end
      a.pins.fwd_pulse_true = (a.st == ST_RUN || a.st == ST_DECEL) && !a.dir
                              && (a.per_cnt < (a.period >> 1));
      a.pins.rev_pulse_true = (a.st == ST_RUN || a.st == ST_DECEL) && a.dir
                              && (a.per_cnt < (a.period >> 1));
      a.pins.fwd_pulse_inv  = !a.pins.fwd_pulse_true;
      a.pins.rev_pulse_inv  = !a.pins.rev_pulse_true;
      a.pins.general_output_dev_clear = (a.gp_cnt != '0) ? a.gp_lvl : a.gout_lvl;
      a.led = lamp_on || (a.err ? next_s.blink : (a.st != ST_IDLE));
      next_s.ax[i] = a;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s          <= '0;
      s.lamp_cnt <= 32'(LAMP_CYC);
      for (int i = 0; i < NUM_AXES; i++) begin
        s.ax[i].st                 <= ST_IDLE;
        s.ax[i].period             <= MIN_PERIOD;
        s.ax[i].led                <= 1'b1;
        s.ax[i].pins.fwd_pulse_inv <= 1'b1;
        s.ax[i].pins.rev_pulse_inv <= 1'b1;
      end
    end else begin
      s <= next_s;
    end
  end

  for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
    assign axis_pins[g] = s.ax[g].pins;
    assign axis_led[g]  = s.ax[g].led;
    assign axis_busy[g] = s.ax[g].st != ST_IDLE;
    assign axis_err[g]  = s.ax[g].err;
    assign axis_pos[g]  = s.ax[g].pos;

    property p_reset_levels;
      @(posedge clk) $rose(rst_b) |-> !s.ax[g].pins.fwd_pulse_true && s.ax[g].pins.fwd_pulse_inv
                                     && !s.ax[g].pins.rev_pulse_true && s.ax[g].pins.rev_pulse_inv;
    endproperty
    a_reset_levels: assert property (p_reset_levels) else $error("pulse pins not at reset levels");

    property p_diff_pair;
      @(posedge clk) disable iff (!rst_b)
        (s.ax[g].pins.fwd_pulse_inv != s.ax[g].pins.fwd_pulse_true)
        && (s.ax[g].pins.rev_pulse_inv != s.ax[g].pins.rev_pulse_true);
    endproperty
    a_diff_pair: assert property (p_diff_pair) else $error("pulse pair not complementary");

    property p_level_cmd;
      @(posedge clk) disable iff (!rst_b)
        out_cmd[g].set && !out_cmd[g].pulse && !devclr_fire[g] && s.ax[g].gp_cnt == '0
        |=> s.ax[g].pins.general_output_dev_clear == $past(out_cmd[g].val);
    endproperty
    a_level_cmd: assert property (p_level_cmd) else $error("general output missed level");

    property p_devclr;
      @(posedge clk) disable iff (!rst_b)
        devclr_fire[g] |=> s.ax[g].pins.general_output_dev_clear == $past(home_cfg[g].dev_clr_lvl)
                           && (s.ax[g].homing == 1'b0 || s.ax[g].hstep == HS_OFFSET);
    endproperty
    a_devclr: assert property (p_devclr) else $error("deviation clear pulse wrong");

    property p_settle_wait;
      @(posedge clk) disable iff (!rst_b)
        s.ax[g].st == ST_SETTLE && mode_cfg[g].inpos_en
        && sense[g].servo_settled_in != mode_cfg[g].inpos_lvl
        && !mode_cfg[g].alarm_en && emergency_halt_in_b |=> s.ax[g].st == ST_SETTLE;
    endproperty
    a_settle_wait: assert property (p_settle_wait) else $error("left settle early");

    property p_alarm_stop;
      @(posedge clk) disable iff (!rst_b)
        mode_cfg[g].alarm_en && sense[g].servo_fault_in == mode_cfg[g].alarm_lvl
        |=> s.ax[g].st == ST_IDLE && s.ax[g].err;
    endproperty
    a_alarm_stop: assert property (p_alarm_stop) else $error("fault did not stop axis");

    property p_fwd_limit;
      @(posedge clk) disable iff (!rst_b)
        s.ax[g].st == ST_RUN && !s.ax[g].dir && !mode_cfg[g].lmt_decel
        && sense[g].fwd_overtravel_in == mode_cfg[g].lmt_lvl
        |=> !s.ax[g].pins.fwd_pulse_true && s.ax[g].st != ST_RUN;
    endproperty
    a_fwd_limit: assert property (p_fwd_limit) else $error("forward limit ignored");

    property p_rev_limit;
      @(posedge clk) disable iff (!rst_b)
        s.ax[g].st == ST_RUN && s.ax[g].dir && sense[g].rev_overtravel_in == mode_cfg[g].lmt_lvl
        |=> s.ax[g].st != ST_RUN && s.ax[g].err;
    endproperty
    a_rev_limit: assert property (p_rev_limit) else $error("reverse limit ignored");

    property p_emg_halt;
      @(posedge clk) disable iff (!rst_b)
        !emergency_halt_in_b |=> !s.ax[g].pins.fwd_pulse_true && !s.ax[g].pins.rev_pulse_true;
    endproperty
    a_emg_halt: assert property (p_emg_halt) else $error("pulses during emergency halt");

    property p_lamp;
      @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> s.ax[g].led [*8];
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp test indicator dark");

    property p_one_pair;
      @(posedge clk) disable iff (!rst_b)
        !(s.ax[g].pins.fwd_pulse_true && s.ax[g].pins.rev_pulse_true);
    endproperty
    a_one_pair: assert property (p_one_pair) else $error("both pairs pulsing");

    c_home_devclr: cover property (@(posedge clk) disable iff (!rst_b) devclr_fire[g]);
    c_limit_stop: cover property (@(posedge clk) disable iff (!rst_b)
      s.ax[g].st == ST_DECEL ##1 s.ax[g].st == ST_IDLE);
    c_emg: cover property (@(posedge clk) disable iff (!rst_b)
      s.ax[g].st == ST_RUN && !emergency_halt_in_b);
    c_settle: cover property (@(posedge clk) disable iff (!rst_b)
      s.ax[g].st == ST_SETTLE ##1 s.ax[g].st == ST_IDLE);
  end

  assign rx_led = s.rx_led;
  assign tx_led = s.tx_led;

endmodule : paxio_ctrl

// >>> hdl/paxio_pkg.sv
// Purpose: shared constants and carrier types for the pulse axis io block
// Assumes: 250 MHz system clock, all inputs synchronous to it
// Notes:   per-axis carriers are packed structs; states are one-hot
package paxio_pkg;
  localparam int          CLK_MHZ      = 250;
  localparam int          LAMP_TEST_MS = 200;
  localparam int          LAMP_CYCLES  = LAMP_TEST_MS * CLK_MHZ * 1000;
  localparam int          BLINK_MS     = 100;
  localparam int          BLINK_CYCLES = BLINK_MS * CLK_MHZ * 1000;
  localparam int          POS_W        = 24;
  localparam int          PER_W        = 16;
  localparam logic [7:0]  DECEL_PULSES = 8'h08;
  localparam logic [PER_W-1:0] MIN_PERIOD = 16'h0002;
  localparam logic [1:0]  HS_NEAR      = 2'h0;
  localparam logic [1:0]  HS_HOME      = 2'h1;
  localparam logic [1:0]  HS_INDEX     = 2'h2;
  localparam logic [1:0]  HS_OFFSET    = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_RUN    = 4'h2,
    ST_DECEL  = 4'h4,
    ST_SETTLE = 4'h8
  } paxio_st_t;

  typedef struct packed {
    logic                    start;
    logic                    home;
    logic                    abs_tgt;
    logic signed [POS_W-1:0] target;
    logic [PER_W-1:0]        period;
  } paxio_cmd_t;

  typedef struct packed {
    logic [3:0]       step_en;
    logic [3:0]       step_rev;
    logic [POS_W-1:0] offset;
    logic             dev_clr_en;
    logic             dev_clr_lvl;
    logic [PER_W-1:0] dev_clr_width;
  } paxio_home_t;

  typedef struct packed {
    logic inpos_en;
    logic inpos_lvl;
    logic alarm_en;
    logic alarm_lvl;
    logic lmt_decel;
    logic lmt_lvl;
  } paxio_mode_t;

  typedef struct packed {
    logic             set;
    logic             val;
    logic             pulse;
    logic [PER_W-1:0] width;
  } paxio_out_t;

  typedef struct packed {
    logic servo_settled_in;
    logic servo_fault_in;
    logic encoder_index_in;
    logic home_sensor_in;
    logic near_home_in;
    logic fwd_overtravel_in;
    logic rev_overtravel_in;
  } paxio_sense_t;

  typedef struct packed {
    logic fwd_pulse_true;
    logic fwd_pulse_inv;
    logic rev_pulse_true;
    logic rev_pulse_inv;
    logic general_output_dev_clear;
  } paxio_pins_t;

  typedef struct packed {
    paxio_st_t               st;
    logic                    dir;
    logic                    homing;
    logic [1:0]              hstep;
    logic [POS_W-1:0]        remain;
    logic signed [POS_W-1:0] pos;
    logic [PER_W-1:0]        per_cnt;
    logic [PER_W-1:0]        period;
    logic [7:0]              decel_left;
    logic                    err;
    logic                    gout_lvl;
    logic [PER_W-1:0]        gp_cnt;
    logic                    gp_lvl;
    logic                    led;
    paxio_pins_t             pins;
  } paxio_axis_t;
endpackage : paxio_pkg
